// ===== inc/reset_wake_pkg.sv
package reset_wake_pkg;
  // register byte offsets
  localparam logic [11:0] OUT_SEL_BASE = 12'h000;
  localparam int OUT_SEL_COUNT = 17;
  localparam logic [11:0] LOCK_OFS = 12'h044;
  localparam logic [11:0] POWER_MASK_BASE = 12'h048;
  localparam logic [11:0] TRIGGER_OFS = 12'h058;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h060;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h064;
  localparam logic [11:0] CORE_CTRL_OFS = 12'h068;
  localparam logic [11:0] CORE_STATE_OFS = 12'h06C;
  localparam logic [11:0] WAKE_CAUSE_OFS = 12'h070;
  // reset values
  localparam logic [4:0] OUT_SEL_RESET = 5'h00;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [7:0] POWER_MASK_RESET = 8'h00;
  localparam logic [1:0] TRIGGER_RESET = 2'h0;
  // implemented bits of each power mask, index 0..3
  localparam logic [7:0] POWER_MASK_IMPL_0 = 8'hFF;
  localparam logic [7:0] POWER_MASK_IMPL_1 = 8'hFE;
  localparam logic [7:0] POWER_MASK_IMPL_2 = 8'h5F;
  localparam logic [7:0] POWER_MASK_IMPL_3 = 8'hFF;
  // vectors and stack
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] LOW_VECTOR = 21'h000018;
  localparam logic [4:0] STACK_PTR_RESET = 5'h00;
  localparam int STACK_DEPTH = 31;
  // interrupt status bits
  localparam int IRQ_COLD_BIT = 0;
  localparam int IRQ_WARM_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam int IRQ_VECTOR_BIT = 3;
  typedef enum logic [1:0] {
    WAKE_NONE,
    WAKE_WATCHDOG,
    WAKE_INT_LOW,
    WAKE_INT_HIGH
  } wake_cause_t;
endpackage

// ===== rtl/reset_init_and_wake_state.sv
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - cold reset zeroes selectors and masks
// - warm resets apply same values as cold
// - watchdog or interrupt wake keeps contents
// - interrupt wake with enable pushes pc unless the stack is full
// - interrupt wake with enable advances stack pointer unless the stack is full
// - interrupt wake with enable loads priority vector
// - every wake updates a cause flag
// - separate program and data buses
module reset_init_and_wake_state
  import reset_wake_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // reset and wake conditions (one-cycle pulses)
  input wire logic i_cold_reset,
  input wire logic i_warm_reset,
  input wire logic i_wake_watchdog,
  input wire logic i_wake_interrupt,
  input wire logic i_wake_high_priority,
  // global enables
  input wire logic i_low_priority_global_enable,
  input wire logic i_high_priority_global_enable,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // program memory bus
  output logic [20:0] o_prog_addr,
  input wire logic [15:0] i_prog_data,
  // data memory bus
  input wire logic i_data_req,
  input wire logic i_data_write,
  input wire logic [11:0] i_data_addr,
  input wire logic [7:0] i_data_wdata,
  output logic [11:0] o_data_mem_addr,
  output logic o_data_mem_we,
  output logic [7:0] o_data_mem_wdata,
  // configuration outputs
  output logic [84:0] o_pin_output_select,
  output logic o_remap_lock,
  output logic [31:0] o_module_power_off_mask,
  output logic [1:0] o_converter_trigger_select,
  // core state
  output logic [4:0] o_return_stack_pointer,
  output logic [7:0] o_stack_top_upper_byte,
  output logic [7:0] o_stack_top_high_byte,
  output logic [7:0] o_stack_top_low_byte,
  output logic [15:0] o_fetched_word,
  // interrupt
  output logic o_irq
);

  typedef struct packed {
    logic [16:0][4:0] out_sel;
    logic lock;
    logic [3:0][7:0] power_mask;
    logic [1:0] trigger;
    logic [20:0] pc;
    logic [4:0] sp;
    logic [30:0][20:0] stack;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    wake_cause_t cause;
    logic [15:0] fetched;
    logic [31:0] prdata;
    logic [11:0] dm_addr;
    logic dm_we;
    logic [7:0] dm_wdata;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic [7:0] impl_mask(input logic [1:0] idx);
    unique case (idx)
      2'd0: impl_mask = POWER_MASK_IMPL_0;
      2'd1: impl_mask = POWER_MASK_IMPL_1;
      2'd2: impl_mask = POWER_MASK_IMPL_2;
      2'd3: impl_mask = POWER_MASK_IMPL_3;
    endcase
  endfunction

  // one selector per aligned word starting at the selector base
  function automatic logic sel_hit(input logic [11:0] a);
    sel_hit = (a >= OUT_SEL_BASE) && (a < OUT_SEL_BASE + 12'(4 * OUT_SEL_COUNT));
  endfunction

  function automatic state_t config_defaults(input state_t s);
    state_t r;
    r = s;
    for (int k = 0; k < OUT_SEL_COUNT; k++) begin
      r.out_sel[k] = OUT_SEL_RESET;
    end
    r.lock = LOCK_RESET;
    for (int k = 0; k < 4; k++) begin
      r.power_mask[k] = POWER_MASK_RESET & impl_mask(2'(k));
    end
    r.trigger = TRIGGER_RESET;
    r.pc = RESET_VECTOR;
    r.sp = STACK_PTR_RESET;
    return r;
  endfunction

  logic setup_phase;
  logic access_wr;
  logic [11:0] word_addr;
  logic global_enable;
  logic [3:0] irq_events;

  assign setup_phase = i_psel && !i_penable;
  assign access_wr = i_psel && i_penable && i_pwrite;
  assign word_addr = {i_paddr[11:2], 2'b00};
  assign global_enable = i_low_priority_global_enable || i_high_priority_global_enable;

  always_comb begin
    next_st = st;
    irq_events = 4'h0;
    // instruction fetch runs every cycle, independent of the data port
    next_st.fetched = i_prog_data;
    next_st.pc = st.pc + 21'd2;
    next_st.dm_addr = i_data_addr;
    next_st.dm_we = i_data_req && i_data_write;
    next_st.dm_wdata = i_data_wdata;

    // software writes land at the access edge; apb has no wait states
    if (access_wr) begin
      if (sel_hit(word_addr)) begin
        next_st.out_sel[5'(word_addr[11:2])] = i_pwdata[4:0];
      end
      unique case (word_addr)
        LOCK_OFS: next_st.lock = i_pwdata[0];
        POWER_MASK_BASE: next_st.power_mask[0] = i_pwdata[7:0] & impl_mask(2'd0);
        POWER_MASK_BASE + 12'h004: next_st.power_mask[1] = i_pwdata[7:0] & impl_mask(2'd1);
        POWER_MASK_BASE + 12'h008: next_st.power_mask[2] = i_pwdata[7:0] & impl_mask(2'd2);
        POWER_MASK_BASE + 12'h00C: next_st.power_mask[3] = i_pwdata[7:0] & impl_mask(2'd3);
        TRIGGER_OFS: next_st.trigger = i_pwdata[1:0];
        IRQ_MASK_OFS: next_st.irq_mask = i_pwdata[3:0];
        IRQ_STATUS_OFS: next_st.irq_status = st.irq_status & ~i_pwdata[3:0];
        WAKE_CAUSE_OFS: next_st.cause = WAKE_NONE;
        default: ;
      endcase
    end

    // cold and warm resets share one set of initial values
    if (i_cold_reset || i_warm_reset) begin
      next_st = config_defaults(next_st);
      irq_events[IRQ_COLD_BIT] = i_cold_reset;
      irq_events[IRQ_WARM_BIT] = i_warm_reset;
    end else if (i_wake_interrupt) begin
      // configuration registers are left as they were
      next_st.cause = i_wake_high_priority ? WAKE_INT_HIGH : WAKE_INT_LOW;
      irq_events[IRQ_WAKE_BIT] = 1'b1;
      if (global_enable) begin
        // full stack drops the push rather than corrupting entries
        if (st.sp < 5'(STACK_DEPTH)) begin
          next_st.stack[st.sp] = st.pc;
          next_st.sp = st.sp + 5'd1;
        end
        next_st.pc = i_wake_high_priority ? HIGH_VECTOR : LOW_VECTOR;
        irq_events[IRQ_VECTOR_BIT] = 1'b1;
      end
    end else if (i_wake_watchdog) begin
      next_st.cause = WAKE_WATCHDOG;
      irq_events[IRQ_WAKE_BIT] = 1'b1;
    end

    // set wins over a clear in the same cycle
    next_st.irq_status = next_st.irq_status | irq_events;

    next_st.prdata = 32'h0000_0000;
    if (setup_phase && !i_pwrite) begin
      if (sel_hit(word_addr)) begin
        next_st.prdata = {27'h0, st.out_sel[5'(word_addr[11:2])]};
      end
      unique case (word_addr)
        LOCK_OFS: next_st.prdata = {31'h0, st.lock};
        POWER_MASK_BASE: next_st.prdata = {24'h0, st.power_mask[0]};
        POWER_MASK_BASE + 12'h004: next_st.prdata = {24'h0, st.power_mask[1]};
        POWER_MASK_BASE + 12'h008: next_st.prdata = {24'h0, st.power_mask[2]};
        POWER_MASK_BASE + 12'h00C: next_st.prdata = {24'h0, st.power_mask[3]};
        TRIGGER_OFS: next_st.prdata = {30'h0, st.trigger};
        IRQ_STATUS_OFS: next_st.prdata = {28'h0, st.irq_status};
        IRQ_MASK_OFS: next_st.prdata = {28'h0, st.irq_mask};
        CORE_STATE_OFS: next_st.prdata = {6'h0, st.sp, st.pc};
        WAKE_CAUSE_OFS: next_st.prdata = {30'h0, st.cause};
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_prdata = st.prdata;
  assign o_prog_addr = st.pc;
  assign o_fetched_word = st.fetched;
  assign o_data_mem_addr = st.dm_addr;
  assign o_data_mem_we = st.dm_we;
  assign o_data_mem_wdata = st.dm_wdata;
  assign o_pin_output_select = st.out_sel;
  assign o_remap_lock = st.lock;
  assign o_module_power_off_mask = st.power_mask;
  assign o_converter_trigger_select = st.trigger;
  assign o_return_stack_pointer = st.sp;
  assign o_stack_top_upper_byte = (st.sp == 5'd0) ? 8'h00 : {3'h0, st.stack[st.sp - 5'd1][20:16]};
  assign o_stack_top_high_byte = (st.sp == 5'd0) ? 8'h00 : st.stack[st.sp - 5'd1][15:8];
  assign o_stack_top_low_byte = (st.sp == 5'd0) ? 8'h00 : st.stack[st.sp - 5'd1][7:0];
  assign o_irq = |(st.irq_status & st.irq_mask);

  // checks sit on the registered outputs or the st register, one cycle after the triggering condition, except mask_unimpl_a which holds on every cycle
  cold_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cold_reset
    |=> (o_pin_output_select == '0) && (o_module_power_off_mask == '0))
    else $error("cold reset left config nonzero");

  warm_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_warm_reset && !i_cold_reset)
    |=> (o_remap_lock == 1'b0) && (o_converter_trigger_select == 2'h0))
    else $error("warm reset left lock or trigger set");

  wake_keeps_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ((i_wake_watchdog || i_wake_interrupt) && !i_cold_reset && !i_warm_reset && !access_wr)
    |=> $stable(o_pin_output_select) && $stable(o_module_power_off_mask) && $stable(o_remap_lock))
    else $error("wake changed configuration");

  push_pc_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wake_interrupt && global_enable && !i_cold_reset && !i_warm_reset && o_return_stack_pointer < 5'd31)
    |=> {o_stack_top_upper_byte[4:0], o_stack_top_high_byte, o_stack_top_low_byte} == $past(o_prog_addr))
    else $error("stack top does not hold pc");

  sp_step_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wake_interrupt && global_enable && !i_cold_reset && !i_warm_reset && o_return_stack_pointer < 5'd31)
    |=> o_return_stack_pointer == $past(o_return_stack_pointer) + 5'd1)
    else $error("stack pointer not advanced");

  vector_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wake_interrupt && global_enable && !i_cold_reset && !i_warm_reset)
    |=> o_prog_addr == ($past(i_wake_high_priority) ? 21'h000008 : 21'h000018))
    else $error("wrong interrupt vector");

  wake_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ((i_wake_watchdog || i_wake_interrupt) && !i_cold_reset && !i_warm_reset)
    |=> st.irq_status[IRQ_WAKE_BIT] && st.cause != WAKE_NONE)
    else $error("wake cause not flagged");

  mask_unimpl_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_module_power_off_mask[8] == 1'b0
    && o_module_power_off_mask[21] == 1'b0 && o_module_power_off_mask[23] == 1'b0)
    else $error("unimplemented mask bit set");

  split_bus_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_data_req
    |=> o_data_mem_addr == $past(i_data_addr) && o_fetched_word == $past(i_prog_data))
    else $error("fetch and data access not concurrent");

  cold_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cold_reset
    |=> (o_remap_lock == 1'b0) && (o_converter_trigger_select == 2'h0))
    else $error("cold reset left lock or trigger set");

  warm_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_warm_reset
    |=> (o_pin_output_select == '0) && (o_module_power_off_mask == '0))
    else $error("warm reset left selectors or masks set");

  reset_sp_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_cold_reset || i_warm_reset)
    |=> o_return_stack_pointer == 5'd0)
    else $error("reset left stack pointer nonzero");

  wake_trig_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ((i_wake_watchdog || i_wake_interrupt) && !i_cold_reset && !i_warm_reset && !access_wr)
    |=> $stable(o_converter_trigger_select))
    else $error("wake changed trigger select");

  wdt_sp_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wake_watchdog && !i_wake_interrupt && !i_cold_reset && !i_warm_reset)
    |=> $stable(o_return_stack_pointer))
    else $error("watchdog wake moved stack pointer");

  no_push_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wake_interrupt && !global_enable && !i_cold_reset && !i_warm_reset)
    |=> $stable(o_return_stack_pointer))
    else $error("push without global enable");

  full_stack_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wake_interrupt && global_enable && !i_cold_reset && !i_warm_reset && o_return_stack_pointer == 5'd31)
    |=> o_return_stack_pointer == 5'd31)
    else $error("full stack pointer moved");

  vec_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wake_interrupt && global_enable && !i_cold_reset && !i_warm_reset)
    |=> st.irq_status[IRQ_VECTOR_BIT])
    else $error("vectored wake not flagged");

  wdt_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wake_watchdog && !i_wake_interrupt && !i_cold_reset && !i_warm_reset)
    |=> st.cause == WAKE_WATCHDOG)
    else $error("watchdog wake cause wrong");

  int_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wake_interrupt && !i_cold_reset && !i_warm_reset)
    |=> st.cause == ($past(i_wake_high_priority) ? WAKE_INT_HIGH : WAKE_INT_LOW))
    else $error("interrupt wake cause wrong");

  data_we_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    1'b1
    |=> o_data_mem_we == $past(i_data_req && i_data_write))
    else $error("data write strobe not passed");

  fetch_step_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!i_cold_reset && !i_warm_reset && !(i_wake_interrupt && global_enable))
    |=> o_prog_addr == $past(o_prog_addr) + 21'd2)
    else $error("fetch address did not advance");

  mask1_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (access_wr && word_addr == POWER_MASK_BASE + 12'h004 && !i_cold_reset && !i_warm_reset)
    |=> o_module_power_off_mask[15:8] == ($past(i_pwdata[7:0]) & POWER_MASK_IMPL_1))
    else $error("mask one write not filtered");

  mask2_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (access_wr && word_addr == POWER_MASK_BASE + 12'h008 && !i_cold_reset && !i_warm_reset)
    |=> o_module_power_off_mask[23:16] == ($past(i_pwdata[7:0]) & POWER_MASK_IMPL_2))
    else $error("mask two write not filtered");

endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import reset_wake_pkg::*;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_cold_reset = 1'b0, i_warm_reset = 1'b0;
  logic i_wake_watchdog = 1'b0, i_wake_interrupt = 1'b0, i_wake_high_priority = 1'b0;
  logic i_low_priority_global_enable = 1'b0, i_high_priority_global_enable = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_data_req = 1'b0, i_data_write = 1'b0;
  logic [11:0] i_paddr = 12'h000, i_data_addr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, o_module_power_off_mask;
  logic [15:0] i_prog_data = 16'h0000, o_fetched_word;
  logic [7:0] i_data_wdata = 8'h00, o_data_mem_wdata, o_stack_top_upper_byte, o_stack_top_high_byte;
  logic [7:0] o_stack_top_low_byte;
  logic o_pready, o_pslverr, o_data_mem_we, o_remap_lock, o_irq;
  logic [20:0] o_prog_addr;
  logic [11:0] o_data_mem_addr;
  logic [84:0] o_pin_output_select;
  logic [1:0] o_converter_trigger_select;
  logic [4:0] o_return_stack_pointer;
  logic [31:0] prdata_q = 32'h0;
  int error_cnt = 0;
  int tests_run = 0;
  logic [7:0] impl [4] = '{POWER_MASK_IMPL_0, POWER_MASK_IMPL_1, POWER_MASK_IMPL_2, POWER_MASK_IMPL_3};

  reset_init_and_wake_state uut (.i_ref_clk, .i_rst, .i_cold_reset, .i_warm_reset, .i_wake_watchdog,
    .i_wake_interrupt, .i_wake_high_priority, .i_low_priority_global_enable, .i_high_priority_global_enable,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_prog_addr,
    .i_prog_data, .i_data_req, .i_data_write, .i_data_addr, .i_data_wdata, .o_data_mem_addr, .o_data_mem_we,
    .o_data_mem_wdata, .o_pin_output_select, .o_remap_lock, .o_module_power_off_mask,
    .o_converter_trigger_select, .o_return_stack_pointer, .o_stack_top_upper_byte, .o_stack_top_high_byte,
    .o_stack_top_low_byte, .o_fetched_word, .o_irq);

  always #2.5 i_ref_clk = ~i_ref_clk;

  // read data as it stood at the rising edge, free of the race with the register update
  always @(posedge i_ref_clk) prdata_q <= o_prdata;

  task automatic chk(input string n, input logic [84:0] exp, input logic [84:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", n, exp, got);
      error_cnt++;
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(negedge i_ref_clk);
    rd = prdata_q;
  endtask

  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    apb(1'b0, a, 32'h0, d);
    chk(n, {53'h0, exp}, {53'h0, d});
  endtask

  function automatic logic [11:0] reg_addr(input int i);
    if (i < OUT_SEL_COUNT) return OUT_SEL_BASE + 12'(4 * i);
    if (i == 17) return LOCK_OFS;
    if (i < 22) return POWER_MASK_BASE + 12'(4 * (i - 18));
    return TRIGGER_OFS;
  endfunction

  // full pattern: every writable bit set, unimplemented mask bits stay zero
  task automatic check_all(input logic full);
    logic [31:0] e;
    for (int i = 0; i < 23; i++) begin
      e = 32'h0;
      if (full) e = (i < 17) ? 32'h1F : (i == 17) ? 32'h1 : (i < 22) ? {24'h0, impl[i - 18]} : 32'h3;
      rd_chk("config register", reg_addr(i), e);
    end
  endtask

  task automatic fill();
    logic [31:0] d;
    for (int i = 0; i < 23; i++) apb(1'b1, reg_addr(i), 32'hFFFFFFFF, d);
  endtask

  task automatic pulse_reset(input logic warm);
    @(posedge i_ref_clk);
    i_cold_reset <= !warm;
    i_warm_reset <= warm;
    @(posedge i_ref_clk);
    i_cold_reset <= 1'b0;
    i_warm_reset <= 1'b0;
  endtask

  // called straight after pulse_reset so the pushed counter value is known: 2
  task automatic wake(input logic wdt, input logic hi);
    @(posedge i_ref_clk);
    i_wake_watchdog <= wdt;
    i_wake_interrupt <= !wdt;
    i_wake_high_priority <= hi;
    @(posedge i_ref_clk);
    i_wake_watchdog <= 1'b0;
    i_wake_interrupt <= 1'b0;
    #1;
  endtask

  task automatic t_keep();
    logic [31:0] d;
    fill();
    chk("mask port", {53'h0, impl[3], impl[2], impl[1], impl[0]}, {53'h0, o_module_power_off_mask});
    chk("select port", {17{5'h1F}}, o_pin_output_select);
    apb(1'b1, IRQ_MASK_OFS, 32'h4, d);
    chk("irq idle", 85'h0, {84'h0, o_irq});
    wake(1'b1, 1'b0);
    check_all(1'b1);
    rd_chk("cause wdt", WAKE_CAUSE_OFS, 32'h1);
    chk("irq on wake", 85'h1, {84'h0, o_irq});
    apb(1'b1, IRQ_STATUS_OFS, 32'hC, d);
    chk("irq cleared", 85'h0, {84'h0, o_irq});
    wake(1'b0, 1'b0);
    check_all(1'b1);
    rd_chk("cause int", WAKE_CAUSE_OFS, 32'h2);
    chk("no push", 85'h0, {80'h0, o_return_stack_pointer});
    $display("wake retention done");
  endtask

  task automatic t_vector(input logic hi);
    pulse_reset(1'b0);
    i_high_priority_global_enable <= hi;
    i_low_priority_global_enable <= !hi;
    wake(1'b0, hi);
    chk("vector", {64'h0, hi ? HIGH_VECTOR : LOW_VECTOR}, {64'h0, o_prog_addr});
    chk("stack ptr", 85'h1, {80'h0, o_return_stack_pointer});
    chk("stack top", 85'h2, {61'h0, o_stack_top_upper_byte, o_stack_top_high_byte, o_stack_top_low_byte});
    rd_chk("cause vec", WAKE_CAUSE_OFS, hi ? 32'h3 : 32'h2);
    i_high_priority_global_enable <= 1'b0;
    i_low_priority_global_enable <= 1'b0;
    check_all(1'b0);
    $display("vectored wake done");
  endtask

  task automatic t_buses();
    @(posedge i_ref_clk);
    i_prog_data <= 16'hA5C3;
    i_data_req <= 1'b1;
    i_data_write <= 1'b1;
    i_data_addr <= 12'h3E1;
    i_data_wdata <= 8'h5A;
    @(posedge i_ref_clk);
    i_data_req <= 1'b0;
    #1;
    chk("fetch", 85'hA5C3, {69'h0, o_fetched_word});
    chk("data", {64'h0, 12'h3E1, 1'b1, 8'h5A}, {64'h0, o_data_mem_addr, o_data_mem_we, o_data_mem_wdata});
    $display("bus split done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    check_all(1'b0);
    t_keep();
    pulse_reset(1'b1);
    check_all(1'b0);
    fill();
    t_vector(1'b1);
    fill();
    t_vector(1'b0);
    t_buses();
    report_and_stop();
  end

  // generous bound: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
